//--- hw/pbsw_pkg.sv
package pbsw_pkg;

  // Long word and lane geometry
  localparam int LONG_W   = 36;
  localparam int BYTE_W   = 9;
  localparam int WORD_W   = 18;
  localparam int Q_DEPTH  = 64;

  // Bus-width select codes {hi, lo}; 2'b00 and 2'b11 are reserved
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  // Swap select codes {hi, lo}
  localparam logic [1:0] SWAP_00 = 2'h0;
  localparam logic [1:0] SWAP_01 = 2'h1;
  localparam logic [1:0] SWAP_10 = 2'h2;
  localparam logic [1:0] SWAP_11 = 2'h3;

  // Phase of the first piece, and phase of the last piece per long word
  localparam logic [1:0] LAST_BYTE_PHASE = 2'h3;
  localparam logic [1:0] LAST_WORD_PHASE = 2'h1;
  localparam logic [1:0] FIRST_PHASE     = 2'h0;

  // Reset values and the byte lane mask
  localparam logic [35:0] LONG_RST = 36'h0;
  localparam logic [8:0]  BYTE_RST = 9'h0;
  localparam logic [8:0]  BYTE_MASK = 9'h1ff;

  // Narrow port lanes
  typedef struct packed {
    logic [8:0] hi;
    logic [8:0] lo;
  } pbsw_lane_t;

endpackage : pbsw_pkg

//--- hw/pbsw_queue.sv
`timescale 1ns/1ns
`default_nettype none

module pbsw_queue #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 64
) (
  input  wire logic             clock_i,    // Core clock
  input  wire logic             reset_i,    // Sync reset, active high
  input  wire logic             push_i,     // Store one long word
  input  wire logic [WIDTH-1:0] push_data_i,// Long word to store
  input  wire logic             pop_i,      // Remove head long word
  output logic      [WIDTH-1:0] head_o,     // Head long word
  output logic                  full_o,     // No room left
  output logic                  empty_n_o   // Low while no long word is visible
);
  localparam int AW = $clog2(DEPTH);

  // Elaboration check: pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_bad
    $error("pbsw_queue: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [AW:0]      count_nxt;
  logic             empty_n_r;
  logic             empty_n_nxt;
  logic             do_push;
  logic             do_pop;

  // Refuse a push when full and a pop when nothing is visible
  assign do_push   = push_i & ~full_o;
  assign do_pop    = pop_i & empty_n_r;
  assign count_nxt = count_r + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
  assign full_o    = (count_r == (AW+1)'(DEPTH));
  assign head_o    = mem[rd_ptr_r];
  assign empty_n_o = empty_n_r;

  // Flag sees the old count, so a fresh word shows one cycle late, a last pop at once
  assign empty_n_nxt = (count_r != '0) && !(do_pop && count_r == (AW+1)'(1));

  always_ff @(posedge clock_i) begin
    if (do_push) begin
      mem[wr_ptr_r] <= push_data_i;
    end
  end

  // Pointers, count and flag
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wr_ptr_r  <= '0;
      rd_ptr_r  <= '0;
      count_r   <= '0;
      empty_n_r <= 1'b0;
    end else begin
      wr_ptr_r  <= wr_ptr_r + AW'(do_push);
      rd_ptr_r  <= rd_ptr_r + AW'(do_pop);
      count_r   <= count_nxt;
      empty_n_r <= empty_n_nxt;
    end
  end

endmodule : pbsw_queue

`default_nettype wire

//--- hw/pbsw_top.sv
`timescale 1ns/1ns
`default_nettype none

// How it works
// - Word writes: two words stored in swap-dependent order into one long word.
// - Byte writes: four bytes stored in swap-dependent order into one long word.
// - Word reads: long word reordered per swap, then sent high half first.
// - Byte reads: long word reordered per swap, then sent one byte at a time.
// - Byte reads leave the unused high output lane holding its last value.
// - Receive parity error covers both lanes in word mode, low lane in byte mode.
// - Transmit empty drops on the read taking the last piece of the last word.
// - Transmit empty rises two cycles after a wide write into an empty queue.
// - Wide empty rises two cycles after a receive write completes a long word.
// - That release is timed from the write of the final piece of the word.
// - Narrow receive pieces gather in a register; the final piece stores the word.
// - On reads, bytes are reordered first, then serialised into words or bytes.
module pbsw_top
  import pbsw_pkg::*;
#(
  parameter int DEPTH = pbsw_pkg::Q_DEPTH
) (
  input  wire logic                  clock_i,              // Core clock
  input  wire logic                  reset_i,              // Sync reset, active high
  input  wire logic                  bus_width_sel_lo_i,   // Bus width select, low bit
  input  wire logic                  bus_width_sel_hi_i,   // Bus width select, high bit
  input  wire logic                  tx_port_swap_sel_lo_i,// Transmit swap, low bit
  input  wire logic                  tx_port_swap_sel_hi_i,// Transmit swap, high bit
  input  wire logic                  rx_port_swap_sel_lo_i,// Receive swap, low bit
  input  wire logic                  rx_port_swap_sel_hi_i,// Receive swap, high bit
  input  wire logic                  parity_odd_i,         // High: odd parity expected
  input  wire logic                  wide_wr_en_i,         // Wide write into outbound queue
  input  wire logic [35:0]           wide_wr_data_i,       // Wide write long word
  output logic                       wide_full_n_o,        // Outbound queue has room
  input  wire logic                  wide_rd_en_i,         // Wide read from inbound queue
  output logic      [35:0]           wide_rd_data_o,       // Wide read long word
  output logic                       wide_port_empty_n_o,  // Inbound long word available
  input  wire logic                  tx_rd_en_i,           // Transmit read strobe
  output pbsw_pkg::pbsw_lane_t       tx_data_o,            // Transmit output register
  output logic                       tx_side_empty_n_o,    // Transmit data available
  input  wire logic                  rx_wr_en_i,           // Receive write strobe
  input  wire pbsw_pkg::pbsw_lane_t  rx_data_i,            // Receive lanes
  output logic                       rx_full_n_o,          // Inbound queue has room
  output logic                       rx_parity_err_n_o     // Receive parity error, low
);
  import pbsw_pkg::*;

  // Elaboration check: the queues need at least two entries
  if (DEPTH < 2) begin : g_depth_bad
    $error("pbsw_top: DEPTH must be at least 2");
  end

  // Long word reorder on the transmit side, bytes A..D most significant first
  function automatic logic [35:0] tx_swap(input logic [35:0] w, input logic [1:0] sel);
    logic [8:0] a;
    logic [8:0] b;
    logic [8:0] c;
    logic [8:0] d;
    a = w[35:27];
    b = w[26:18];
    c = w[17:9];
    d = w[8:0];
    case (sel)
      SWAP_00: tx_swap = {a, b, c, d};
      SWAP_01: tx_swap = {d, c, b, a};
      SWAP_10: tx_swap = {c, d, a, b};
      default: tx_swap = {b, a, d, c};
    endcase
  endfunction : tx_swap

  // Arrival-ordered bytes r0..r3 into the stored long word
  function automatic logic [35:0] rx_perm(input logic [35:0] raw, input logic [1:0] sel,
                                          input logic byte_mode);
    logic [8:0] r0;
    logic [8:0] r1;
    logic [8:0] r2;
    logic [8:0] r3;
    r0 = raw[35:27];
    r1 = raw[26:18];
    r2 = raw[17:9];
    r3 = raw[8:0];
    if (byte_mode) begin
      case (sel)
        SWAP_00: rx_perm = {r3, r2, r1, r0};
        SWAP_01: rx_perm = {r0, r1, r2, r3};
        SWAP_10: rx_perm = {r1, r0, r3, r2};
        default: rx_perm = {r2, r3, r0, r1};
      endcase
    end else begin
      case (sel)
        SWAP_00: rx_perm = {r2, r3, r0, r1};
        SWAP_01: rx_perm = {r1, r0, r3, r2};
        SWAP_10: rx_perm = {r0, r1, r2, r3};
        default: rx_perm = {r3, r2, r1, r0};
      endcase
    end
  endfunction : rx_perm

  // Configuration decode; reserved width codes fall back to word size
  logic       byte_mode;
  logic [1:0] tx_sel;
  logic [1:0] rx_sel;
  logic [1:0] last_phase;
  assign byte_mode  = ({bus_width_sel_hi_i, bus_width_sel_lo_i} == SIZE_BYTE);
  assign tx_sel     = {tx_port_swap_sel_hi_i, tx_port_swap_sel_lo_i};
  assign rx_sel     = {rx_port_swap_sel_hi_i, rx_port_swap_sel_lo_i};
  assign last_phase = byte_mode ? LAST_BYTE_PHASE : LAST_WORD_PHASE;

  // Queue wiring
  logic        q1_full;
  logic        q1_empty_n;
  logic [35:0] q1_head;
  logic        q1_pop;
  logic        q2_full;
  logic        q2_empty_n;
  logic [35:0] q2_head;
  logic        q2_push;
  logic [35:0] q2_word;
  logic        q2_pop;

  pbsw_queue #(.WIDTH(LONG_W), .DEPTH(DEPTH)) u_outbound_queue (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .push_i      (wide_wr_en_i),
    .push_data_i (wide_wr_data_i),
    .pop_i       (q1_pop),
    .head_o      (q1_head),
    .full_o      (q1_full),
    .empty_n_o   (q1_empty_n)
  );

  pbsw_queue #(.WIDTH(LONG_W), .DEPTH(DEPTH)) u_inbound_queue (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .push_i      (q2_push),
    .push_data_i (q2_word),
    .pop_i       (q2_pop),
    .head_o      (q2_head),
    .full_o      (q2_full),
    .empty_n_o   (q2_empty_n)
  );

  // Transmit side: reorder on load, then serialise piece by piece
  logic [1:0]  tx_phase_r;
  logic [1:0]  tx_phase_nxt;
  logic [35:0] tx_word_r;
  logic [35:0] tx_src;
  logic        tx_fire;
  logic        tx_load_new;
  logic [5:0]  tx_shift;
  logic [35:0] tx_shifted;
  pbsw_lane_t  tx_data_r;
  pbsw_lane_t  tx_data_nxt;

  // Pieces still waiting in the auxiliary register keep the flag high
  assign tx_side_empty_n_o = (tx_phase_r != FIRST_PHASE) | q1_empty_n;
  assign tx_fire     = tx_rd_en_i & tx_side_empty_n_o;
  assign tx_load_new = tx_fire & (tx_phase_r == FIRST_PHASE);
  assign q1_pop      = tx_load_new;
  assign tx_src      = (tx_phase_r == FIRST_PHASE) ? tx_swap(q1_head, tx_sel) : tx_word_r;
  // Pick the current piece by shifting it to the top of the word
  assign tx_shift    = byte_mode ? 6'(BYTE_W * tx_phase_r) : 6'(WORD_W * tx_phase_r);
  assign tx_shifted  = tx_src << tx_shift;
  assign tx_phase_nxt = (tx_phase_r == last_phase) ? FIRST_PHASE : tx_phase_r + 2'h1;

  // Byte mode touches only the low lane, which also saves toggling power
  always_comb begin
    tx_data_nxt = tx_data_r;
    if (byte_mode) begin
      tx_data_nxt.lo = tx_shifted[35:27];
    end else begin
      tx_data_nxt.hi = tx_shifted[35:27];
      tx_data_nxt.lo = tx_shifted[26:18];
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tx_phase_r <= FIRST_PHASE;
      tx_word_r  <= LONG_RST;
      tx_data_r  <= '{hi: BYTE_RST, lo: BYTE_RST};
    end else if (tx_fire) begin
      tx_phase_r <= tx_phase_nxt;
      tx_data_r  <= tx_data_nxt;
      if (tx_load_new) begin
        tx_word_r <= tx_src;
      end
    end
  end
  assign tx_data_o = tx_data_r;

  // Receive side: gather pieces, reorder when the long word is complete
  logic [1:0]  rx_phase_r;
  logic [35:0] rx_raw_r;
  logic        rx_fire;
  logic        rx_last;
  logic [5:0]  rx_shift;
  logic [35:0] rx_ins;
  logic [35:0] rx_mask;
  logic [35:0] rx_assembled;

  // Whole receive writes stall while the inbound queue is full
  assign rx_full_n_o = ~q2_full;
  assign rx_fire     = rx_wr_en_i & rx_full_n_o;
  assign rx_last     = rx_phase_r == last_phase;
  // Slot for this piece, counted from the top in arrival order
  assign rx_shift    = byte_mode ? 6'(BYTE_W * (LAST_BYTE_PHASE - rx_phase_r))
                                 : 6'(WORD_W * (LAST_WORD_PHASE - rx_phase_r));
  assign rx_ins      = byte_mode ? ({27'h0, rx_data_i.lo} << rx_shift)
                                 : ({18'h0, rx_data_i} << rx_shift);
  assign rx_mask     = byte_mode ? ({27'h0, BYTE_MASK} << rx_shift)
                                 : ({18'h0, BYTE_MASK, BYTE_MASK} << rx_shift);
  assign rx_assembled = (rx_raw_r & ~rx_mask) | rx_ins;

  // The final piece's edge stores the reordered long word, which starts the flag delay
  assign q2_push = rx_fire & rx_last;
  assign q2_word = rx_perm(rx_assembled, rx_sel, byte_mode);

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rx_phase_r <= FIRST_PHASE;
      rx_raw_r   <= LONG_RST;
    end else if (rx_fire) begin
      rx_phase_r <= rx_last ? FIRST_PHASE : rx_phase_r + 2'h1;
      rx_raw_r   <= rx_assembled;
    end
  end

  // Parity check on the lanes in use, live on the receive inputs
  logic err_hi;
  logic err_lo;
  assign err_lo = (^rx_data_i.lo) != parity_odd_i;
  assign err_hi = (^rx_data_i.hi) != parity_odd_i;
  assign rx_parity_err_n_o = ~(err_lo | (err_hi & ~byte_mode));

  // Wide side: outbound writes and registered inbound reads
  logic [35:0] wide_rd_data_r;
  assign wide_full_n_o       = ~q1_full;
  assign wide_port_empty_n_o = q2_empty_n;
  assign q2_pop              = wide_rd_en_i & q2_empty_n;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wide_rd_data_r <= LONG_RST;
    end else if (q2_pop) begin
      wide_rd_data_r <= q2_head;
    end
  end
  assign wide_rd_data_o = wide_rd_data_r;

endmodule : pbsw_top

`default_nettype wire

//--- tb/pbsw_host.sv
`timescale 1ns/1ns
`default_nettype none
module pbsw_host
  import pbsw_pkg::*;
(
  input  wire logic            clock_i,      // Clock
  input  wire logic            rx_full_n_i,  // Inbound room
  input  wire logic            tx_empty_n_i, // Tx data ready
  output logic                 rx_wr_en_o,   // Write strobe
  output pbsw_pkg::pbsw_lane_t rx_data_o,    // Write lanes
  output logic                 tx_rd_en_o    // Read strobe
);
  logic f;
  int   hang = 0;

  // Idle bus at start
  initial begin
    rx_wr_en_o = 1'b0;
    rx_data_o  = '0;
    tx_rd_en_o = 1'b0;
  end

  // Request held to the taking edge; released lanes show the inverse, never the old value
  task automatic put(input pbsw_lane_t v, input bit more);
    rx_data_o <= v;
    rx_wr_en_o <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(negedge clock_i) f = rx_full_n_i;
      @(posedge clock_i);
      if (f) break;
      if (i == 19) hang++;
    end
    #1;
    if (!more) begin
      rx_wr_en_o <= 1'b0;
      rx_data_o <= ~v;
    end
  endtask : put

  // One piece read; strobe stays up for back-to-back reads
  task automatic get(input bit more);
    tx_rd_en_o <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(negedge clock_i) f = tx_empty_n_i;
      @(posedge clock_i);
      if (f) break;
      if (i == 19) hang++;
    end
    #1;
    if (!more) tx_rd_en_o <= 1'b0;
  endtask : get
endmodule : pbsw_host
`default_nettype wire

//--- tb/pbsw_props.sv
`timescale 1ns/1ns
`default_nettype none
module pbsw_props
  import pbsw_pkg::*;
(
  input wire logic                 clock_i,             // Clock
  input wire logic                 reset_i,             // Reset
  input wire logic                 bus_width_sel_lo_i,  // Width low
  input wire logic                 bus_width_sel_hi_i,  // Width high
  input wire logic                 parity_odd_i,        // Odd parity
  input wire logic                 wide_wr_en_i,        // Wide write
  input wire logic                 wide_full_n_o,       // Wide room
  input wire logic                 wide_port_empty_n_o, // Wide data
  input wire logic                 tx_rd_en_i,          // Tx read
  input wire pbsw_pkg::pbsw_lane_t tx_data_o,           // Tx lanes
  input wire logic                 tx_side_empty_n_o,   // Tx data
  input wire logic                 rx_wr_en_i,          // Rx write
  input wire pbsw_pkg::pbsw_lane_t rx_data_i,           // Rx lanes
  input wire logic                 rx_full_n_o,         // Rx room
  input wire logic                 rx_parity_err_n_o    // Parity flag
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);

  logic [1:0] tx_ph_r;
  logic [1:0] rx_ph_r;
  // Reserved width codes count as word, as the designer chose
  wire logic       byte_m    = bus_width_sel_lo_i & ~bus_width_sel_hi_i;
  wire logic [1:0] last_ph   = byte_m ? LAST_BYTE_PHASE : LAST_WORD_PHASE;
  wire logic       tx_go     = tx_rd_en_i & tx_side_empty_n_o;
  wire logic       rx_go     = rx_wr_en_i & rx_full_n_o;
  wire logic       tx_last   = tx_go & (tx_ph_r == last_ph);
  wire logic       rx_last   = rx_go & (rx_ph_r == last_ph);
  wire logic [1:0] tx_ph_nxt = tx_last ? FIRST_PHASE : tx_ph_r + 2'h1;
  wire logic [1:0] rx_ph_nxt = rx_last ? FIRST_PHASE : rx_ph_r + 2'h1;
  wire logic       perr_lo   = (^rx_data_i.lo) != parity_odd_i;
  wire logic       perr_hi   = (^rx_data_i.hi) != parity_odd_i;

  // Own piece counters, so a phase slip in the design shows as a flag error
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tx_ph_r <= FIRST_PHASE;
      rx_ph_r <= FIRST_PHASE;
    end else begin
      if (tx_go) tx_ph_r <= tx_ph_nxt;
      if (rx_go) rx_ph_r <= rx_ph_nxt;
    end
  end

  tx_release_a: assert property (wide_wr_en_i && wide_full_n_o && !tx_side_empty_n_o
    |-> ##2 tx_side_empty_n_o) else $error("tx empty flag not released");
  tx_rise_cause_a: assert property ($rose(tx_side_empty_n_o) |-> $past(wide_wr_en_i, 2))
    else $error("tx empty flag rose without a wide write");
  tx_drop_last_a: assert property ($fell(tx_side_empty_n_o) |-> $past(tx_last) || $past(reset_i))
    else $error("tx empty flag fell off the last piece");
  mid_word_a: assert property (tx_go && !tx_last |=> tx_side_empty_n_o)
    else $error("tx empty flag fell inside a long word");
  rx_release_a: assert property (rx_last && !wide_port_empty_n_o |-> ##2 wide_port_empty_n_o)
    else $error("wide empty flag not released");
  rx_rise_cause_a: assert property ($rose(wide_port_empty_n_o) |-> $past(rx_last, 2))
    else $error("wide empty flag rose without a final piece");
  parity_lanes_a: assert property (rx_parity_err_n_o == !(perr_lo || (!byte_m && perr_hi)))
    else $error("parity flag lanes wrong");
  hi_lane_hold_a: assert property (byte_m |=> $stable(tx_data_o.hi))
    else $error("unused tx lane changed in byte mode");

  // Main scenarios reached
  cover property (tx_last && byte_m);
  cover property (rx_last && !byte_m);
  cover property (!rx_parity_err_n_o && byte_m);
endmodule : pbsw_props

bind pbsw_top pbsw_props u_props (
  .clock_i(clock_i), .reset_i(reset_i), .bus_width_sel_lo_i(bus_width_sel_lo_i),
  .bus_width_sel_hi_i(bus_width_sel_hi_i), .parity_odd_i(parity_odd_i),
  .wide_wr_en_i(wide_wr_en_i), .wide_full_n_o(wide_full_n_o),
  .wide_port_empty_n_o(wide_port_empty_n_o), .tx_rd_en_i(tx_rd_en_i), .tx_data_o(tx_data_o),
  .tx_side_empty_n_o(tx_side_empty_n_o), .rx_wr_en_i(rx_wr_en_i), .rx_data_i(rx_data_i),
  .rx_full_n_o(rx_full_n_o), .rx_parity_err_n_o(rx_parity_err_n_o)
);
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pbsw_pkg::*;

  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        sz_lo   = 1'b0;
  logic        sz_hi   = 1'b1;
  logic [1:0]  tsw     = 2'h0;
  logic [1:0]  rsw     = 2'h0;
  logic        par_odd = 1'b0;
  logic        wwr     = 1'b0;
  logic        wrd     = 1'b0;
  logic [35:0] wdata   = 36'h0;
  logic [35:0] rdata;
  logic        full_n, wempty_n, tx_empty_n, tx_en, rx_en, rx_full_n, perr_n;
  pbsw_lane_t  tx_data, rx_d;
  logic [35:0] q[$];
  logic [31:0] seed = 32'h4df0;
  int          err_total = 0;
  int          num_checks = 0;
  // Byte order per swap code, most significant first: reads, then word writes
  logic [7:0]  rdt[4] = '{8'h1b, 8'he4, 8'hb1, 8'h4e};
  logic [7:0]  wwt[4] = '{8'hb1, 8'h4e, 8'h1b, 8'he4};

  pbsw_top u_dut (
    .clock_i(clock_i), .reset_i(reset_i), .bus_width_sel_lo_i(sz_lo),
    .bus_width_sel_hi_i(sz_hi), .tx_port_swap_sel_lo_i(tsw[0]), .tx_port_swap_sel_hi_i(tsw[1]),
    .rx_port_swap_sel_lo_i(rsw[0]), .rx_port_swap_sel_hi_i(rsw[1]), .parity_odd_i(par_odd),
    .wide_wr_en_i(wwr), .wide_wr_data_i(wdata), .wide_full_n_o(full_n), .wide_rd_en_i(wrd),
    .wide_rd_data_o(rdata), .wide_port_empty_n_o(wempty_n), .tx_rd_en_i(tx_en),
    .tx_data_o(tx_data), .tx_side_empty_n_o(tx_empty_n), .rx_wr_en_i(rx_en),
    .rx_data_i(rx_d), .rx_full_n_o(rx_full_n), .rx_parity_err_n_o(perr_n)
  );
  pbsw_host u_host (
    .clock_i(clock_i), .rx_full_n_i(rx_full_n), .tx_empty_n_i(tx_empty_n),
    .rx_wr_en_o(rx_en), .rx_data_o(rx_d), .tx_rd_en_o(tx_en)
  );

  // 100 ns clock
  initial begin
    forever #50 clock_i = ~clock_i;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [35:0] perm(input logic [35:0] w, input logic [7:0] t);
    for (int k = 0; k < 4; k++) perm[35-9*k -: 9] = w[35-9*t[7-2*k -: 2] -: 9];
  endfunction : perm

  // Byte mode checks the low lane only
  function automatic logic pfail(input pbsw_lane_t d);
    return ((^d.lo) != par_odd) || (!sz_lo && ((^d.hi) != par_odd));
  endfunction : pfail

  // Fresh long word from the bench LFSR
  function automatic logic [35:0] rnd();
    repeat (36) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return {seed[3:0], seed};
  endfunction : rnd

  task automatic wide_put(input logic [35:0] v, input bit more);
    wwr <= 1'b1;
    wdata <= v;
    @(posedge clock_i);
    if (!more) wwr <= 1'b0;
  endtask : wide_put

  task automatic wide_get(output logic [35:0] v);
    logic f;
    wrd <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(negedge clock_i) f = wempty_n;
      @(posedge clock_i);
      if (f) break;
      if (i == 7) begin
        err_total++;
        report_and_stop();
      end
    end
    wrd <= 1'b0;
    @(negedge clock_i) v = rdata;
    @(posedge clock_i);
  endtask : wide_get

  // Byte and word width codes and every swap code; selects move only while reset is held
  initial begin : main
    logic [35:0] v;
    logic [35:0] r;
    int n;
    for (int c = 0; c < 8; c++) begin
      reset_i <= 1'b1;
      {sz_hi, sz_lo} <= c[2] ? SIZE_BYTE : SIZE_WORD;
      tsw <= c[1:0];
      rsw <= ~c[1:0];
      par_odd <= c[0];
      repeat (20) @(posedge clock_i);
      chk({full_n, rx_full_n, tx_empty_n, wempty_n}, 4'hc);
      reset_i <= 1'b0;
      n = c[2] ? 4 : 2;
      for (int k = 0; k < 2; k++) begin
        v = rnd();
        q.push_back(v);
        wide_put(v, k == 0);
      end
      for (int k = 0; k < 2; k++) begin
        r = perm(q.pop_front(), rdt[c[1:0]]);
        for (int p = 0; p < n; p++) begin
          u_host.get(k == 0 || p < n - 1);
          if (c[2]) chk(tx_data, {9'h0, r[35-9*p -: 9]});
          else chk(tx_data, r[35-18*p -: 18]);
        end
      end
      chk(tx_empty_n, 1'b0);
      @(posedge clock_i);
      // Byte table is the word table indexed by the inverted code
      for (int k = 0; k < 2; k++) begin
        v = rnd();
        q.push_back(perm(v, wwt[c[2] ? ~rsw : rsw]));
        for (int p = 0; p < n; p++) begin
          u_host.put(c[2] ? {v[8:0], v[35-9*p -: 9]} : v[35-18*p -: 18],
                     p < n - 1 && !(k == 0 && p == n - 2));
          #1;
          chk(perr_n, !pfail(rx_d));
          if (k == 0 && p == n - 2) begin
            repeat (3) @(negedge clock_i);
            chk(wempty_n, 1'b0);
            // Restart on a rising edge so the final piece is taken only once
            @(posedge clock_i);
          end
        end
      end
      @(posedge clock_i);
      for (int k = 0; k < 2; k++) begin
        wide_get(r);
        chk(r, q.pop_front());
      end
      chk(wempty_n, 1'b0);
      $display("config %0d done", c);
    end
    chk(u_host.hang, 0);
    report_and_stop();
  end

  // Hang guard
  initial begin
    repeat (5000) @(posedge clock_i);
    err_total++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
